// >>> hw/ppc_ctrl.sv
// Purpose: Bus decode, adapter register file and supply select control of the programmer.
// Assumes: clk_sys at 20 MHz; microprocessor bus pins are asynchronous and synchronised here.
// Notes:   Registers reachable from AXI4-Lite and from the microprocessor bus.
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`include "ppc_regs.svh"
module ppc_ctrl
	import ppc_pkg::*;
#(
	parameter int AXI_AW = 8
) (
	input  wire logic              clk_sys,
	input  wire logic              nrst,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire ppc_mbus_t         mbus_in,
	input  wire logic [7:0]        mbus_data_in,
	output logic [7:0]             mbus_data_out,
	output logic                   mbus_data_oe,
	output logic                   mbus_rd_en,
	output logic                   mbus_wr_en,
	input  wire logic              relocation_jumper_n,
	input  wire logic [7:0]        socket_data_line,
	output logic [7:0]             programmer_data_line,
	output logic                   low_step_supply_select,
	output logic                   mid_step_supply_select,
	output logic                   driver_bus_gate_select,
	output logic                   converter_boost_select,
	output logic                   extra_boost_select,
	output logic                   program_pin_enable_n,
	output logic                   driver_strobe,
	output logic                   erasable_program_enable,
	output logic                   readback_enable_n,
	output logic                   adapter_control_out_two
);

	// Byte offsets below need at least six address bits.
	if (AXI_AW < 6) begin : g_aw_check
		$error("AXI_AW must be at least 6");
	end

	logic [7:0]  adp_q [0:7];
	ppc_mbus_t   mb_s1_q;
	ppc_mbus_t   mb_s2_q;
	ppc_mbus_t   mb_s3_q;
	logic [7:0]  md_s1_q;
	logic [7:0]  md_s2_q;
	logic [7:0]  md_s3_q;
	logic        jmp_s1_q;
	logic        jmp_s2_q;
	logic [7:0]  sock_s1_q;
	logic [7:0]  sock_s2_q;
	logic [15:0] base;
	logic        sel2;
	logic        sel3;
	logic        mb_wr;
	logic        aw_go;
	logic        ax_wr;
	logic        ax_wmap;
	logic [2:0]  ax_widx;
	logic        ax_rmap;
	logic        ax_rstat;
	logic [2:0]  ax_ridx;
	ppc_supply_t req;
	ppc_supply_t sup_q;
	logic        attempt;
	logic        bipolar;
	logic        legal;
	logic        multi;
	logic        refuse;
	logic        pat_err_q;
	logic        bit_err_q;
	logic        stat_clr;

	// Every asynchronous pin passes two flip-flops; the third bus and data stage feeds the write strobe, its address and its data.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			mb_s1_q   <= '0;
			mb_s2_q   <= '0;
			mb_s3_q   <= '0;
			md_s1_q   <= 8'h00;
			md_s2_q   <= 8'h00;
			md_s3_q   <= 8'h00;
			jmp_s1_q  <= 1'b1;
			jmp_s2_q  <= 1'b1;
			sock_s1_q <= 8'h00;
			sock_s2_q <= 8'h00;
		end else begin
			mb_s1_q   <= mbus_in;
			mb_s2_q   <= mb_s1_q;
			mb_s3_q   <= mb_s2_q;
			md_s1_q   <= mbus_data_in;
			md_s2_q   <= md_s1_q;
			md_s3_q   <= md_s2_q;
			jmp_s1_q  <= relocation_jumper_n;
			jmp_s2_q  <= jmp_s1_q;
			sock_s1_q <= socket_data_line;
			sock_s2_q <= sock_s1_q;
		end
	end

	// Window decode: upper bits and the valid address qualifier select the module.
	assign base = jmp_s2_q ? `PPC_BASE_MAIN : `PPC_BASE_ALT;
	assign sel2 = mb_s2_q.valid_user_address && (mb_s2_q.addr[15:3] == base[15:3]);
	assign sel3 = mb_s3_q.valid_user_address && (mb_s3_q.addr[15:3] == base[15:3]);
	// A write lands at the falling edge of phase 2, when bus data has settled.
	assign mb_wr = sel3 && !mb_s3_q.rw && mb_s3_q.phi2 && !mb_s2_q.phi2;

	// Transceiver enables from phase 2 and read/write; both low when not selected.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			mbus_rd_en    <= 1'b0;
			mbus_wr_en    <= 1'b0;
			mbus_data_oe  <= 1'b0;
			mbus_data_out <= 8'h00;
		end else begin
			mbus_rd_en    <= sel2 && mb_s2_q.phi2 && mb_s2_q.rw;
			mbus_wr_en    <= sel2 && mb_s2_q.phi2 && !mb_s2_q.rw;
			mbus_data_oe  <= sel2 && mb_s2_q.phi2 && mb_s2_q.rw;
			// Low three bits pick adapter and register.
			mbus_data_out <= adp_q[mb_s2_q.addr[2:0]];
		end
	end

	// AXI write: both channels are taken together once both are valid.
	assign aw_go   = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	assign ax_wr   = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	assign ax_wmap = (s_axi_awaddr[1:0] == 2'h0) && (s_axi_awaddr <= AXI_AW'(`PPC_OFF_LAST));
	assign ax_widx = s_axi_awaddr[4:2];
	assign stat_clr = ax_wr && (s_axi_awaddr == AXI_AW'(`PPC_OFF_STAT)) && s_axi_wstrb[0];

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PPC_RESP_OKAY;
		end else begin
			s_axi_awready <= aw_go;
			s_axi_wready  <= aw_go;
			if (ax_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (ax_wmap || stat_clr || s_axi_awaddr == AXI_AW'(`PPC_OFF_STAT))
					? `PPC_RESP_OKAY : `PPC_RESP_SLV;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Adapter file; reset clears every byte, and the microprocessor bus wins a same-cycle clash.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			for (int i = 0; i < 8; i++) begin
				adp_q[i] <= `PPC_ADP_RST;
			end
		end else begin
			if (ax_wr && ax_wmap && s_axi_wstrb[0]) begin
				adp_q[ax_widx] <= s_axi_wdata[7:0];
			end
			if (mb_wr) begin
				adp_q[mb_s3_q.addr[2:0]] <= md_s3_q;
			end
		end
	end

	// AXI read: one address phase, then the word stands until rready.
	assign ax_rmap  = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= AXI_AW'(`PPC_OFF_LAST));
	assign ax_rstat = s_axi_araddr == AXI_AW'(`PPC_OFF_STAT);
	assign ax_ridx  = s_axi_araddr[4:2];

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `PPC_RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= (ax_rmap || ax_rstat) ? `PPC_RESP_OKAY : `PPC_RESP_SLV;
				if (ax_rmap && ax_ridx == `PPC_IDX_SOCK) begin
					s_axi_rdata <= {24'h000000, sock_s2_q};
				end else if (ax_rmap) begin
					s_axi_rdata <= {24'h000000, adp_q[ax_ridx]};
				end else if (ax_rstat) begin
					s_axi_rdata <= {16'h0000, sock_s2_q, 6'h00, bit_err_q, pat_err_q};
				end else begin
					s_axi_rdata <= 32'h0000_0000;
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Requested pattern and its legality; a mixed or unknown pattern is refused whole.
	assign req     = ppc_supply_t'(adp_q[`PPC_IDX_SUPPLY][5:0]);
	assign attempt = adp_q[`PPC_IDX_MODE][`PPC_B_ATTEMPT];
	assign bipolar = req != '0;
	always_comb begin
		case (6'(req))
			6'h00:           legal = 1'b1;
			`PPC_PAT_LOW:    legal = 1'b1;
			`PPC_PAT_LOWPP:  legal = 1'b1;
			`PPC_PAT_MID:    legal = 1'b1;
			`PPC_PAT_MIDGT:  legal = 1'b1;
			`PPC_PAT_BOOST:  legal = 1'b1;
			`PPC_PAT_BOOSTX: legal = 1'b1;
			default:         legal = 1'b0;
		endcase
		// Erasable programming never shares an attempt with a bipolar family.
		if (bipolar && adp_q[`PPC_IDX_SUPPLY][`PPC_B_EROM]) begin
			legal = 1'b0;
		end
	end
	// Bipolar parts take one bit per attempt; a word with two or more bits set is refused.
	assign multi  = bipolar && ((adp_q[`PPC_IDX_DATA] & (adp_q[`PPC_IDX_DATA] - 8'h01)) != 8'h00);
	assign refuse = attempt && (!legal || multi);

	// Supply and drive outputs, all inactive outside an accepted attempt, program_pin_enable_n then high.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			sup_q                   <= '0;
			program_pin_enable_n    <= 1'b1;
			driver_strobe           <= 1'b0;
			erasable_program_enable <= 1'b0;
		end else begin
			sup_q <= (attempt && !refuse) ? req : '0;
			// The active-low pin has its own flop, so no inverter sits between flop and pin.
			program_pin_enable_n <= !(attempt && !refuse && req.pp_en);
			driver_strobe <= attempt && !refuse
				&& adp_q[`PPC_IDX_SUPPLY][`PPC_B_STROBE];
			erasable_program_enable <= attempt && !refuse
				&& adp_q[`PPC_IDX_SUPPLY][`PPC_B_EROM];
		end
	end

	// Separate pins keep the board wiring obvious; the program pin enable is active low.
	assign low_step_supply_select = sup_q.low_step;
	assign mid_step_supply_select = sup_q.mid_step;
	assign driver_bus_gate_select = sup_q.gate;
	assign converter_boost_select = sup_q.conv_boost;
	assign extra_boost_select     = sup_q.extra_boost;

	// Data word, readback path and hold-off select.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			programmer_data_line    <= 8'h00;
			readback_enable_n       <= 1'b1;
			adapter_control_out_two <= 1'b0;
		end else begin
			readback_enable_n <= !adp_q[`PPC_IDX_MODE][`PPC_B_RDBK];
			// While reading back, the socket lines are returned onto the data lines.
			programmer_data_line <= adp_q[`PPC_IDX_MODE][`PPC_B_RDBK] ? sock_s2_q
				: (refuse ? 8'h00 : adp_q[`PPC_IDX_DATA]);
			adapter_control_out_two <= adp_q[`PPC_IDX_CTLB][`PPC_B_CO2];
		end
	end

	// Sticky refusal flags; a new refusal wins over a clear in the same cycle.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pat_err_q <= 1'b0;
			bit_err_q <= 1'b0;
		end else begin
			pat_err_q <= (attempt && !legal) || (pat_err_q && !(stat_clr && s_axi_wdata[0]));
			bit_err_q <= (attempt && multi) || (bit_err_q && !(stat_clr && s_axi_wdata[1]));
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence s_accept;
		attempt && !refuse;
	endsequence

	sequence s_mb_read;
		sel2 && mb_s2_q.phi2 && mb_s2_q.rw;
	endsequence

	a_idle_supply: assert property (!attempt |=> sup_q == '0 && !driver_strobe)
		else $error("supply select active outside an attempt");
	a_low_step: assert property (s_accept ##0 req.low_step |=> low_step_supply_select)
		else $error("low-step select missing");
	a_mid_step: assert property (s_accept ##0 req.mid_step |=> mid_step_supply_select)
		else $error("mid-step select missing");
	a_boost_level: assert property (s_accept ##0 req.conv_boost |=> converter_boost_select)
		else $error("converter boost missing");
	a_extra_pair: assert property (extra_boost_select |-> converter_boost_select)
		else $error("extra boost without converter boost");
	a_gate_pair: assert property (driver_bus_gate_select |-> mid_step_supply_select)
		else $error("driver gate without mid-step select");
	a_strobe_gate: assert property (driver_strobe |-> $past(attempt))
		else $error("strobe outside an attempt");
	a_pin_enable: assert property (!program_pin_enable_n |-> low_step_supply_select)
		else $error("program pin enabled without low-step");
	a_erom_alone: assert property (erasable_program_enable |-> sup_q == '0)
		else $error("erasable enable mixed with bipolar select");
	a_one_bit: assert property (s_accept ##0 bipolar ##1 1'b1 |-> $onehot0(programmer_data_line)
		|| !readback_enable_n)
		else $error("more than one bit driven for bipolar part");
	a_readback: assert property (adp_q[`PPC_IDX_MODE][`PPC_B_RDBK] |=> !readback_enable_n
		&& programmer_data_line == $past(sock_s2_q))
		else $error("readback path not returned");
	a_bus_float: assert property (!sel2 |=> !mbus_data_oe && !mbus_wr_en)
		else $error("transceiver enabled while not selected");
	a_read_drive: assert property (s_mb_read |=> mbus_data_oe
		&& mbus_data_out == $past(adp_q[mb_s2_q.addr[2:0]]))
		else $error("selected read not driven");
	a_write_store: assert property (mb_wr |=>
		adp_q[$past(mb_s3_q.addr[2:0])] == $past(md_s3_q))
		else $error("selected write not stored");
	a_family_legal: assert property (attempt && !legal |=> sup_q == '0)
		else $error("illegal supply pattern reached the pins");
	a_reset_clear: assert property (@(posedge clk_sys) disable iff (1'b0)
		!nrst |=> adp_q[`PPC_IDX_SUPPLY] == 8'h00 && adp_q[`PPC_IDX_MODE] == 8'h00)
		else $error("adapter bytes not cleared by reset");

	// Host bus side: the two transceiver directions never open together.
	a_rw_exclusive: assert property (!(mbus_rd_en && mbus_wr_en))
		else $error("read and write enables both high");
	// A selected write opens the receivers and never drives the bus.
	a_write_enable: assert property (sel2 && mb_s2_q.phi2 && !mb_s2_q.rw |=>
		mbus_wr_en && !mbus_data_oe)
		else $error("selected write did not open receivers");
	// An unselected cycle leaves the read enable low as well.
	a_read_float: assert property (!sel2 |=> !mbus_rd_en)
		else $error("read enable while not selected");
	// The hold-off select follows its control bit one cycle later.
	a_hold_off: assert property (1'b1 |=> adapter_control_out_two
		== $past(adp_q[`PPC_IDX_CTLB][`PPC_B_CO2]))
		else $error("hold-off select does not follow its bit");

	// Accepted attempts: every requested select must reach its pin.
	a_erom_gate: assert property (s_accept ##0
		adp_q[`PPC_IDX_SUPPLY][`PPC_B_EROM] |=> erasable_program_enable)
		else $error("erasable enable missing");
	a_strobe_on: assert property (s_accept ##0
		adp_q[`PPC_IDX_SUPPLY][`PPC_B_STROBE] |=> driver_strobe)
		else $error("driver strobe missing");
	a_extra_level: assert property (s_accept ##0 req.extra_boost |=>
		extra_boost_select && converter_boost_select)
		else $error("extra boost pair missing");
	a_gate_level: assert property (s_accept ##0 req.gate |=>
		driver_bus_gate_select && mid_step_supply_select)
		else $error("driver bus gate pair missing");
	a_pin_low: assert property (s_accept ##0 req.pp_en |=>
		!program_pin_enable_n && low_step_supply_select)
		else $error("program pin enable missing");

	// Refused attempts: nothing reaches the pins, and the sticky flags record why.
	a_refuse_quiet: assert property (refuse |=>
		sup_q == '0 && !driver_strobe && !erasable_program_enable)
		else $error("refused attempt reached the pins");
	a_bit_refuse: assert property (attempt && multi
		&& !adp_q[`PPC_IDX_MODE][`PPC_B_RDBK] |=> programmer_data_line == 8'h00)
		else $error("multi-bit word driven to a bipolar part");
	a_pattern_flag: assert property (attempt && !legal |=> pat_err_q)
		else $error("pattern refusal not recorded");
	a_multi_flag: assert property (attempt && multi |=> bit_err_q)
		else $error("multi-bit refusal not recorded");

endmodule : ppc_ctrl

// >>> hw/ppc_regs.svh
// Purpose: Offsets, field positions, reset values and fixed patterns of the programmer control.
// Assumes: Included by its bare name from the bench and the control module.
// Notes:   Adapter bytes sit one per 32-bit word in the low byte.
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

`define PPC_BASE_MAIN  16'hEC08
`define PPC_BASE_ALT   16'hBC08
`define PPC_ADP_RST    8'h00
`define PPC_OFF_STAT   8'h20
`define PPC_OFF_LAST   8'h1C
`define PPC_IDX_DATA   3'h0
`define PPC_IDX_SUPPLY 3'h2
`define PPC_IDX_CTLB   3'h3
`define PPC_IDX_MODE   3'h4
`define PPC_IDX_SOCK   3'h6
`define PPC_B_STROBE   6
`define PPC_B_EROM     7
`define PPC_B_CO2      3
`define PPC_B_ATTEMPT  0
`define PPC_B_RDBK     1
`define PPC_PAT_LOW    6'h01
`define PPC_PAT_LOWPP  6'h21
`define PPC_PAT_MID    6'h02
`define PPC_PAT_MIDGT  6'h06
`define PPC_PAT_BOOST  6'h08
`define PPC_PAT_BOOSTX 6'h18
`define PPC_RESP_OKAY  2'h0
`define PPC_RESP_SLV   2'h2

`endif

// >>> hw/ppc_pkg.sv
// Purpose: Types shared by the programmer control.
// Assumes: Constants come from ppc_regs.svh.
// Notes:   Supply struct order matches the low six bits of the supply byte.
package ppc_pkg;
	// Supply select pattern, enable of the program pin held active high here.
	typedef struct packed {
		logic pp_en;
		logic extra_boost;
		logic conv_boost;
		logic gate;
		logic mid_step;
		logic low_step;
	} ppc_supply_t;

	// Microprocessor bus control and address pins.
	typedef struct packed {
		logic [15:0] addr;
		logic        valid_user_address;
		logic        rw;
		logic        phi2;
	} ppc_mbus_t;
endpackage : ppc_pkg

// >>> sim/ppc_host_model.sv
// Purpose: Host bus and socket side facing the programmer control.
// Assumes: Cycles are issued one at a time from the bench.
// Notes:   A released bus shows the inverse of the cycle's address and of d; after a read, that data is the value already driven.
`timescale 1ns/10ps
module ppc_host_model
	import ppc_pkg::*;
#(
	parameter logic [7:0] SOCK_BYTE = 8'hA5
) (
	input  wire logic       clk_sys,
	output ppc_mbus_t       mbus_in,
	output logic [7:0]      mbus_data_in,
	output logic [7:0]      socket_data_line,
	input  wire logic [7:0] mbus_data_out,
	input  wire logic       mbus_data_oe,
	input  wire logic       mbus_rd_en,
	input  wire logic       mbus_wr_en
);
	// Idle bus at time zero; the socket holds one fixed pattern.
	initial begin
		mbus_in = '{addr: 16'h0000, valid_user_address: 1'b0, rw: 1'b1, phi2: 1'b0};
		mbus_data_in = 8'h00;
		socket_data_line = SOCK_BYTE;
	end

	// One bus cycle; rw stays put through the whole phase-2 window.
	task cycle(input logic [15:0] a, input logic v, input logic rd, input logic [7:0] d,
		output logic [7:0] q, output logic [2:0] en);
		@(posedge clk_sys);
		mbus_in <= '{addr: a, valid_user_address: v, rw: rd, phi2: 1'b0};
		mbus_data_in <= rd ? ~d : d;
		repeat (2) @(posedge clk_sys);
		mbus_in.phi2 <= 1'b1;
		repeat (5) @(posedge clk_sys);
		q = mbus_data_out;
		en = {mbus_data_oe, mbus_rd_en, mbus_wr_en};
		@(posedge clk_sys);
		mbus_in.phi2 <= 1'b0;
		repeat (6) @(posedge clk_sys);
		mbus_in <= '{addr: ~a, valid_user_address: 1'b0, rw: 1'b1, phi2: 1'b0};
		mbus_data_in <= ~d;
	endtask : cycle
endmodule : ppc_host_model

// >>> sim/ppc_ctrl_bench.sv
// Purpose: Self-checking bench of the programmer control.
// Assumes: Register bytes sit one per word; the socket shows 8'hA5.
// Notes:   Outputs are settled two edges before they are compared.
`timescale 1ns/10ps
`include "ppc_regs.svh"
module ppc_ctrl_bench
	import ppc_pkg::*;
;
	logic clk_sys, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, mbus_data_in, mbus_data_out;
	logic [7:0] socket_data_line, programmer_data_line, q;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [2:0] en;
	ppc_mbus_t mbus_in;
	logic mbus_data_oe, mbus_rd_en, mbus_wr_en, relocation_jumper_n;
	logic low_step_supply_select, mid_step_supply_select, driver_bus_gate_select;
	logic converter_boost_select, extra_boost_select, program_pin_enable_n, driver_strobe;
	logic erasable_program_enable, readback_enable_n, adapter_control_out_two;
	logic [7:0] sup_seen;
	logic [15:0] pats [8];
	int miscompares = 0;
	int checked = 0;

	// Supply outputs gathered in supply-byte order, program pin enable made active high.
	assign sup_seen = {erasable_program_enable, driver_strobe, ~program_pin_enable_n,
		extra_boost_select, converter_boost_select, driver_bus_gate_select,
		mid_step_supply_select, low_step_supply_select};

	ppc_ctrl i_ppc_ctrl (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mbus_in, .mbus_data_in, .mbus_data_out,
		.mbus_data_oe, .mbus_rd_en, .mbus_wr_en, .relocation_jumper_n, .socket_data_line,
		.programmer_data_line, .low_step_supply_select, .mid_step_supply_select,
		.driver_bus_gate_select, .converter_boost_select, .extra_boost_select,
		.program_pin_enable_n, .driver_strobe, .erasable_program_enable, .readback_enable_n,
		.adapter_control_out_two);

	ppc_host_model i_ppc_host_model (.clk_sys, .mbus_in, .mbus_data_in, .socket_data_line,
		.mbus_data_out, .mbus_data_oe, .mbus_rd_en, .mbus_wr_en);

	// Clock at 20 MHz.
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Write with address and data offered together; bready held until bvalid.
	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ad, wd;
		n = 0;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ad && wd) && n < 100) begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awready === 1'b1) begin
				s_axi_awvalid <= 1'b0;
				ad = 1'b1;
			end
			if (s_axi_wready === 1'b1) begin
				s_axi_wvalid <= 1'b0;
				wd = 1'b1;
			end
		end
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		s_axi_bready <= 1'b0;
		check({30'h0, s_axi_bresp}, {30'h0, er});
		if (n >= 100) miscompares++;
		repeat (2) @(posedge clk_sys);
	endtask : axw

	// Read and compare data and response.
	task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		check(rv, ed);
		check({30'h0, rr}, {30'h0, er});
		if (n >= 100) miscompares++;
	endtask : axr

	task print_verdict;
		$display("counts: checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict

	// Hang guard, far beyond the few hundred cycles the tests need.
	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		print_verdict();
	end

	// Tests.
	initial begin
		pats = '{16'h0101, 16'h2101, 16'h0201, 16'h0601, 16'h0801, 16'h1801, 16'h4601, 16'h80FF};
		nrst = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		relocation_jumper_n = 1'b1;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check({program_pin_enable_n, readback_enable_n, sup_seen}, 10'h300);
		// Over AXI, byte six reads the synchronised socket lines, not a stored value.
		for (int i = 0; i < 8; i++) begin
			axr(8'(4 * i), (i == 6) ? 32'hA5 : 32'h0, `PPC_RESP_OKAY);
		end
		$display("test reset done");
		axw(8'h10, 32'h01, `PPC_RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			axw(8'h00, {24'h0, pats[i][7:0]}, `PPC_RESP_OKAY);
			axw(8'h08, {24'h0, pats[i][15:8]}, `PPC_RESP_OKAY);
			check(sup_seen, pats[i][15:8]);
			check(programmer_data_line, pats[i][7:0]);
		end
		// The last loop step put a full byte under the erasable enable; start clean.
		axw(8'h00, 32'h01, `PPC_RESP_OKAY);
		axw(8'h08, 32'h18, `PPC_RESP_OKAY);
		check(sup_seen, 8'h18);
		axw(8'h10, 32'h00, `PPC_RESP_OKAY);
		check(sup_seen, 8'h00);
		axw(8'h20, 32'h03, `PPC_RESP_OKAY);
		axr(8'h20, 32'hA500, `PPC_RESP_OKAY);
		$display("test supply patterns done");
		axw(8'h10, 32'h01, `PPC_RESP_OKAY);
		axw(8'h08, 32'h03, `PPC_RESP_OKAY);
		check(sup_seen, 8'h00);
		axr(8'h20, 32'hA501, `PPC_RESP_OKAY);
		// A clear while the refusal still stands loses to it.
		axw(8'h20, 32'h01, `PPC_RESP_OKAY);
		axr(8'h20, 32'hA501, `PPC_RESP_OKAY);
		axw(8'h08, 32'h01, `PPC_RESP_OKAY);
		axw(8'h20, 32'h01, `PPC_RESP_OKAY);
		axr(8'h20, 32'hA500, `PPC_RESP_OKAY);
		axw(8'h00, 32'h03, `PPC_RESP_OKAY);
		axw(8'h08, 32'h46, `PPC_RESP_OKAY);
		check({programmer_data_line, sup_seen}, 16'h0000);
		axr(8'h20, 32'hA502, `PPC_RESP_OKAY);
		axw(8'h08, 32'h81, `PPC_RESP_OKAY);
		check(sup_seen, 8'h00);
		$display("test refusals done");
		axw(8'h10, 32'h03, `PPC_RESP_OKAY);
		check({readback_enable_n, programmer_data_line}, 9'h0A5);
		axw(8'h10, 32'h00, `PPC_RESP_OKAY);
		axw(8'h0C, 32'h08, `PPC_RESP_OKAY);
		check(adapter_control_out_two, 1'b1);
		axw(8'h0C, 32'h00, `PPC_RESP_OKAY);
		check(adapter_control_out_two, 1'b0);
		axw(8'h24, 32'h01, `PPC_RESP_SLV);
		axw(8'h02, 32'h01, `PPC_RESP_SLV);
		axr(8'h24, 32'h0, `PPC_RESP_SLV);
		$display("test readback and map done");
		i_ppc_host_model.cycle(16'hEC0B, 1'b1, 1'b0, 8'h08, q, en);
		check(en, 3'b001);
		repeat (2) @(posedge clk_sys);
		check(adapter_control_out_two, 1'b1);
		i_ppc_host_model.cycle(16'hEC0B, 1'b1, 1'b1, 8'h00, q, en);
		check({en, q}, 11'h608);
		axw(8'h14, 32'h5A, `PPC_RESP_OKAY);
		i_ppc_host_model.cycle(16'hEC0D, 1'b1, 1'b1, 8'h00, q, en);
		check({en, q}, 11'h65A);
		i_ppc_host_model.cycle(16'hEC0D, 1'b0, 1'b1, 8'h00, q, en);
		check(en, 3'b000);
		i_ppc_host_model.cycle(16'hEC10, 1'b1, 1'b1, 8'h00, q, en);
		check(en, 3'b000);
		i_ppc_host_model.cycle(16'hEC07, 1'b1, 1'b0, 8'h77, q, en);
		check(en, 3'b000);
		relocation_jumper_n <= 1'b0;
		i_ppc_host_model.cycle(16'hBC0D, 1'b1, 1'b1, 8'h00, q, en);
		check({en, q}, 11'h65A);
		i_ppc_host_model.cycle(16'hEC0D, 1'b1, 1'b1, 8'h00, q, en);
		check(en, 3'b000);
		$display("test host bus done");
		axw(8'h00, 32'h01, `PPC_RESP_OKAY);
		axw(8'h10, 32'h01, `PPC_RESP_OKAY);
		axw(8'h08, 32'h08, `PPC_RESP_OKAY);
		check(sup_seen, 8'h08);
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check({program_pin_enable_n, sup_seen}, 9'h100);
		axr(8'h14, 32'h0, `PPC_RESP_OKAY);
		axr(8'h10, 32'h0, `PPC_RESP_OKAY);
		$display("test abort by reset done");
		print_verdict();
	end
endmodule : ppc_ctrl_bench
